// file: cie_pkg.sv
// Purpose: Shared constants and types for the instruction execute subset
// Assumes: 14-bit opcodes, 7-bit file addresses, 8-bit data
// Notes:   Register offsets for the APB window live here too
package cie_pkg;
   // Opcode and operand widths
   localparam int OP_W   = 14;
   localparam int FA_W   = 7;
   localparam int DW     = 8;
   localparam int PC_W   = 12;
   localparam int STK_N  = 8;
   localparam int STK_AW = 3;

   // Opcode fields
   localparam logic [5:0]  GRP_STORE   = 6'h00;
   localparam logic [5:0]  GRP_SUB     = 6'h02;
   localparam logic [5:0]  GRP_XORF    = 6'h06;
   localparam logic [5:0]  GRP_ZTEST   = 6'h08;
   localparam logic [5:0]  GRP_ROTR    = 6'h0C;
   localparam logic [5:0]  GRP_ROTL    = 6'h0D;
   localparam logic [5:0]  GRP_SWAP    = 6'h0E;
   localparam logic [5:0]  GRP_RETLIT  = 6'h18;
   localparam logic [5:0]  GRP_LDLIT   = 6'h19;
   localparam logic [5:0]  GRP_XORLIT  = 6'h1F;
   localparam logic [13:0] OPC_NOOP    = 14'h0000;
   localparam logic [13:0] OPC_RETSUB  = 14'h0040;
   localparam logic [13:0] OPC_RETINT  = 14'h0060;
   localparam logic [13:0] OPC_SLEEP   = 14'h008A;

   // Bit positions inside the opcode
   localparam int D_BIT  = 7;
   localparam int GRP_LO = 8;

   // APB register byte offsets
   localparam logic [11:0] REG_CTRL    = 12'h000;
   localparam logic [11:0] REG_OPCODE  = 12'h004;
   localparam logic [11:0] REG_STATE   = 12'h008;
   localparam logic [11:0] REG_PC      = 12'h00C;
   localparam logic [11:0] REG_STKPUSH = 12'h010;

   // Field positions in the control and state registers
   localparam int CTRL_WAKE   = 0;
   localparam int ST_ACC_LO   = 0;
   localparam int ST_C        = 8;
   localparam int ST_DCAR     = 9;
   localparam int ST_Z        = 10;
   localparam int ST_IEN      = 11;
   localparam int ST_SLEEP    = 12;
   localparam int ST_BUSY     = 13;

   // Reset values
   localparam logic [DW-1:0]   ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST  = 12'h000;

   // Execution states
   typedef enum logic [1:0] {
      EX_IDLE  = 2'b00,
      EX_FILE  = 2'b01,
      EX_FLUSH = 2'b11,
      EX_SLEEP = 2'b10
   } cie_ex_t;

   // File register access bundle
   typedef struct packed {
      logic            wr;
      logic [FA_W-1:0] addr;
      logic [DW-1:0]   wdata;
   } cie_file_t;

   // Flag bundle
   typedef struct packed {
      logic c;
      logic dcar;
      logic z;
   } cie_flags_t;
endpackage

// file: cie_alu.sv
// Purpose: Combinational arithmetic and logic for one executed opcode
// Assumes: Operands presented in the same cycle as the opcode
// Notes:   Flags not touched by an opcode pass through unchanged
module cie_alu
   import cie_pkg::*;
(
   // Operands
   input  wire logic [OP_W-1:0] op_in,
   input  wire logic [DW-1:0]   acc_in,
   input  wire logic [DW-1:0]   file_in,
   input  wire cie_flags_t      flags_in,
   // Results
   output logic      [DW-1:0]   res_out,
   output cie_flags_t           flags_out,
   output logic                 to_file_out,
   output logic                 to_acc_out
);
   logic [5:0]    grp;
   logic [DW:0]   diff;
   logic [4:0]    ndiff;
   logic [DW-1:0] lit;

   assign grp = op_in[OP_W-1:GRP_LO];
   assign lit = op_in[DW-1:0];

   // Result, flags and destination selection
   always_comb begin
      diff        = {1'b0, file_in} + {1'b0, ~acc_in} + 9'h001;
      ndiff       = {1'b0, file_in[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;
      res_out     = acc_in;
      flags_out   = flags_in;
      to_file_out = 1'b0;
      to_acc_out  = 1'b0;
      unique case (grp)
         GRP_LDLIT: begin
            res_out    = lit;
            to_acc_out = 1'b1;
         end
         GRP_RETLIT: begin
            res_out    = lit;
            to_acc_out = 1'b1;
         end
         GRP_XORLIT: begin
            res_out     = acc_in ^ lit;
            flags_out.z = (res_out == 8'h00);
            to_acc_out  = 1'b1;
         end
         GRP_STORE: begin
            // Standby shares this group but stores nothing
            if (op_in[D_BIT] && op_in != OPC_SLEEP) begin
               res_out     = acc_in;
               to_file_out = 1'b1;
            end
         end
         GRP_ZTEST: begin
            if (op_in[D_BIT]) begin
               flags_out.z = (file_in == 8'h00);
            end
         end
         GRP_SUB: begin
            res_out      = diff[DW-1:0];
            flags_out.c  = diff[DW];
            flags_out.dcar = ndiff[4];
            flags_out.z  = (diff[DW-1:0] == 8'h00);
         end
         GRP_XORF: begin
            res_out     = acc_in ^ file_in;
            flags_out.z = (res_out == 8'h00);
         end
         GRP_ROTL: begin
            res_out     = {file_in[6:0], flags_in.c};
            flags_out.c = file_in[7];
         end
         GRP_ROTR: begin
            res_out     = {flags_in.c, file_in[7:1]};
            flags_out.c = file_in[0];
         end
         GRP_SWAP: res_out = {file_in[3:0], file_in[7:4]};
         default: ;
      endcase
      // Destination bit picks accumulator or file
      if (grp == GRP_SUB || grp == GRP_XORF || grp == GRP_ROTL ||
          grp == GRP_ROTR || grp == GRP_SWAP) begin
         to_file_out = op_in[D_BIT];
         to_acc_out  = ~op_in[D_BIT];
      end
   end
endmodule

// file: cie_stack.sv
// Purpose: Return address stack built from flip-flops
// Assumes: Push with pop in one cycle replaces the top entry
// Notes:   Overflow wraps, underflow wraps; depth fixed
module cie_stack
   import cie_pkg::*;
(
   // Clock and reset
   input  wire logic            clk_sys_in,
   input  wire logic            nrst_in,
   // Control
   input  wire logic            push_in,
   input  wire logic [PC_W-1:0] push_val_in,
   input  wire logic            pop_in,
   // Top entry
   output logic      [PC_W-1:0] top_out
);
   typedef struct packed {
      logic [STK_N-1:0][PC_W-1:0] ent;
      logic [STK_AW-1:0]          sp;
   } cie_stk_t;

   cie_stk_t st_q;
   cie_stk_t st_d;
   logic [STK_AW-1:0] wr_idx;

   assign top_out = st_q.ent[st_q.sp - 3'h1];

   // Push writes at the pointer, pop steps it back; both at once
   // overwrite the popped entry so neither request is lost
   always_comb begin
      st_d   = st_q;
      wr_idx = pop_in ? st_q.sp - 3'h1 : st_q.sp;
      for (int i = 0; i < STK_N; i++) begin
         if (push_in && wr_idx == i[STK_AW-1:0]) begin
            st_d.ent[i] = push_val_in;
         end
      end
      if (push_in && !pop_in) begin
         st_d.sp = st_q.sp + 3'h1;
      end else if (pop_in && !push_in) begin
         st_d.sp = st_q.sp - 3'h1;
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// file: cie_core.sv
// Purpose: Executes a subset of a 14-bit opcode set on an 8-bit datapath
// Assumes: Program memory and file register answer combinationally
// Notes:   APB window for test control, state view and stack seeding
// What this block does
// - File address 7 bits, literals 8 bits
// - Destination bit: 0 accumulator, 1 file
// - Load literal to accumulator, one cycle
// - Store accumulator to file, one cycle
// - Interrupt return pops stack, sets enable, two cycles
// - Literal return loads accumulator, pops, two cycles
// - Subroutine return pops stack, two cycles
// - Rotate left through carry, one cycle
// - Rotate right through carry, one cycle
// - Sleep opcode enters standby, stops clock
// - Carry means no borrow; zero on zero
// - Swap file nibbles, flags unchanged
// - Zero test sets Z only with destination bit set, writes nothing
// - Xor literal into accumulator, sets Z
// - Xor accumulator with file, sets Z
//
// The APB slave port and the address map were left to the implementer.
module cie_core
   import cie_pkg::*;
(
   // Clock and reset
   input  wire logic            clk_sys_in,
   input  wire logic            nrst_in,
   // APB slave
   input  wire logic            psel_in,
   input  wire logic            penable_in,
   input  wire logic            pwrite_in,
   input  wire logic [11:0]     paddr_in,
   input  wire logic [31:0]     pwdata_in,
   output logic      [31:0]     prdata_out,
   output logic                 pready_out,
   output logic                 pslverr_out,
   // Program memory
   output logic      [PC_W-1:0] pm_addr_out,
   input  wire logic [OP_W-1:0] pm_data_in,
   // File register
   output logic      [FA_W-1:0] fr_addr_out,
   input  wire logic [DW-1:0]   fr_rdata_in,
   output logic                 fr_wr_out,
   output logic      [DW-1:0]   fr_wdata_out,
   // Status
   output logic                 ien_out,
   output logic                 osc_stop_out
);
   // All module state
   typedef struct packed {
      cie_ex_t         ex;
      logic [PC_W-1:0] pc;
      logic [OP_W-1:0] ir;
      logic [DW-1:0]   acc;
      cie_flags_t      flags;
      logic            ien;
      logic            sleep;
      cie_file_t       fw;
      logic [31:0]     prdata;
      logic            pready;
      logic            pslverr;
      logic [PC_W-1:0] pm_addr;
   } cie_state_t;

   cie_state_t s_q;
   cie_state_t s_d;

   logic [DW-1:0]   alu_res;
   cie_flags_t      alu_flags;
   logic            alu_to_file;
   logic            alu_to_acc;
   logic [PC_W-1:0] stk_top;
   logic            stk_push;
   logic            stk_pop;
   logic            is_rtn;
   logic            apb_acc;
   logic            apb_wr;
   logic [DW-1:0]   file_val;

   // Forward a file write still in flight to the next opcode, so a
   // read of the register just written sees the new value
   assign file_val = (s_q.fw.wr && s_q.fw.addr == s_q.ir[FA_W-1:0]) ?
                     s_q.fw.wdata : fr_rdata_in;

   // Arithmetic unit on the latched opcode
   cie_alu u_alu (
      .op_in       (s_q.ir),
      .acc_in      (s_q.acc),
      .file_in     (file_val),
      .flags_in    (s_q.flags),
      .res_out     (alu_res),
      .flags_out   (alu_flags),
      .to_file_out (alu_to_file),
      .to_acc_out  (alu_to_acc)
   );

   // Return address stack
   cie_stack u_stack (
      .clk_sys_in  (clk_sys_in),
      .nrst_in     (nrst_in),
      .push_in     (stk_push),
      .push_val_in (pwdata_in[PC_W-1:0]),
      .pop_in      (stk_pop),
      .top_out     (stk_top)
   );

   // Bus phase decode
   assign apb_acc  = psel_in & penable_in & ~s_q.pready;
   assign apb_wr   = apb_acc & pwrite_in;
   assign stk_push = apb_wr & (paddr_in == REG_STKPUSH);
   assign is_rtn   = (s_q.ir == OPC_RETSUB) || (s_q.ir == OPC_RETINT) ||
                     (s_q.ir[OP_W-1:GRP_LO] == GRP_RETLIT);
   assign stk_pop  = (s_q.ex == EX_FILE) && is_rtn;

   // Operand address is the low seven opcode bits
   assign fr_addr_out = s_q.ir[FA_W-1:0];

   // Next-state logic: fetch, execute, flush, sleep and bus
   always_comb begin
      s_d          = s_q;
      s_d.fw.wr    = 1'b0;
      s_d.pready   = 1'b0;
      s_d.pslverr  = 1'b0;
      unique case (s_q.ex)
         EX_IDLE: begin
            // Latch the first opcode after reset
            s_d.ir      = pm_data_in;
            s_d.pc      = s_q.pc + 12'h001;
            s_d.pm_addr = s_q.pc + 12'h001;
            s_d.ex      = EX_FILE;
         end
         EX_FILE: begin
            // Execute the latched opcode and fetch the next one, except after a return or sleep
            s_d.flags = alu_flags;
            if (alu_to_acc) begin
               s_d.acc = alu_res;
            end
            if (alu_to_file) begin
               s_d.fw.wr    = 1'b1;
               s_d.fw.addr  = s_q.ir[FA_W-1:0];
               s_d.fw.wdata = alu_res;
            end
            if (is_rtn) begin
               s_d.pc      = stk_top;
               s_d.pm_addr = stk_top;
               s_d.ex      = EX_FLUSH;
               if (s_q.ir == OPC_RETINT) begin
                  s_d.ien = 1'b1;
               end
            end else if (s_q.ir == OPC_SLEEP) begin
               s_d.sleep = 1'b1;
               s_d.ex    = EX_SLEEP;
            end else begin
               // No operation and unassigned codes fall through here
               s_d.ir      = pm_data_in;
               s_d.pc      = s_q.pc + 12'h001;
               s_d.pm_addr = s_q.pc + 12'h001;
            end
         end
         EX_FLUSH: begin
            // Second cycle of a return fetches at the new PC
            s_d.ir      = pm_data_in;
            s_d.pc      = s_q.pc + 12'h001;
            s_d.pm_addr = s_q.pc + 12'h001;
            s_d.ex      = EX_FILE;
         end
         EX_SLEEP: begin
            // Standby until software wakes the core
            if (apb_wr && paddr_in == REG_CTRL && pwdata_in[CTRL_WAKE]) begin
               s_d.sleep = 1'b0;
               s_d.ir    = OPC_NOOP;
               s_d.ex    = EX_FILE;
            end
         end
         default: s_d.ex = EX_IDLE;
      endcase

      // APB access: one wait state, answer in the next cycle
      if (apb_acc) begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         unique case (paddr_in)
            REG_CTRL: ;
            REG_STKPUSH: ;
            REG_OPCODE: begin
               s_d.prdata[OP_W-1:0] = s_q.ir;
               s_d.pslverr = pwrite_in;
            end
            REG_STATE: begin
               s_d.prdata[ST_ACC_LO +: DW] = s_q.acc;
               s_d.prdata[ST_C]     = s_q.flags.c;
               s_d.prdata[ST_DCAR]  = s_q.flags.dcar;
               s_d.prdata[ST_Z]     = s_q.flags.z;
               s_d.prdata[ST_IEN]   = s_q.ien;
               s_d.prdata[ST_SLEEP] = s_q.sleep;
               s_d.prdata[ST_BUSY]  = (s_q.ex == EX_FLUSH);
               if (pwrite_in) begin
                  // Interrupt return in the same cycle wins over a clear
                  s_d.ien = pwdata_in[ST_IEN] ||
                            (s_q.ex == EX_FILE && s_q.ir == OPC_RETINT);
               end
            end
            REG_PC: begin
               s_d.prdata[PC_W-1:0] = s_q.pc;
               s_d.pslverr = pwrite_in;
            end
            default: s_d.pslverr = 1'b1;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q       <= '0;
         s_q.ex    <= EX_IDLE;
         s_q.acc   <= ACC_RST;
         s_q.pc    <= PC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign prdata_out   = s_q.prdata;
   assign pready_out   = s_q.pready;
   assign pslverr_out  = s_q.pslverr;
   assign pm_addr_out  = s_q.pm_addr;
   assign fr_wr_out    = s_q.fw.wr;
   assign fr_wdata_out = s_q.fw.wdata;
   assign ien_out      = s_q.ien;
   assign osc_stop_out = s_q.sleep;
endmodule

// file: cie_core_assertions.sv
// Purpose: Port timing checks for the execute subset
// Assumes: One clock, async active-low reset
// Notes:   Helper flags hold opcodes fetched one and two edges ago
module cie_core_assertions
   import cie_pkg::*;
(
   // Clock and reset
   input wire logic            clk_sys_in,
   input wire logic            nrst_in,
   // APB
   input wire logic            psel_in,
   input wire logic            penable_in,
   input wire logic            pwrite_in,
   input wire logic [11:0]     paddr_in,
   input wire logic            pready_out,
   input wire logic            pslverr_out,
   // Core side
   input wire logic [PC_W-1:0] pm_addr_out,
   input wire logic [OP_W-1:0] pm_data_in,
   input wire logic            fr_wr_out,
   input wire logic            ien_out,
   input wire logic            osc_stop_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] grp;
   logic       wcap, ctrl_wr, state_wr;
   logic       rtn_p1, slp_p1, slp_p2, rti_p1, rti_p2, wc_p1, wc_p2;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   // Fetched opcode that may write a file register
   assign grp = pm_data_in[13:8];
   assign wcap = (pm_data_in[13:7] == 7'h01 && pm_data_in != OPC_SLEEP) ||
      (pm_data_in[D_BIT] && (grp == 6'h02 || grp == 6'h06 || grp == 6'h0C ||
      grp == 6'h0D || grp == 6'h0E));
   assign ctrl_wr = psel_in && pwrite_in && paddr_in == REG_CTRL;
   // Edge at which the core takes a state write
   assign state_wr = psel_in && penable_in && pwrite_in && !pready_out && paddr_in == REG_STATE;

   // Fetch history
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {rtn_p1, slp_p1, slp_p2, rti_p1, rti_p2, wc_p1, wc_p2} <= '0;
      end else begin
         rtn_p1 <= pm_data_in == 14'h0040 || pm_data_in == 14'h0060 || grp == 6'h18;
         rti_p1 <= pm_data_in == 14'h0060;
         rti_p2 <= rti_p1;
         slp_p1 <= pm_data_in == OPC_SLEEP;
         slp_p2 <= slp_p1;
         wc_p1  <= wcap;
         wc_p2  <= wc_p1;
      end
   end

   sequence apb_wait;
      psel_in && penable_in && !pready_out;
   endsequence

   chk_apb_answer: assert property (apb_wait |=> pready_out)
      else $error("apb answer late");
   chk_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   chk_err_unmapped: assert property (apb_wait and paddr_in > REG_STKPUSH |=> pslverr_out)
      else $error("unmapped access accepted");
   chk_err_alone: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   chk_wr_cause: assert property (fr_wr_out |-> wc_p2)
      else $error("file write without writing opcode");
   chk_ien_cause: assert property ($rose(ien_out) |-> rti_p2 || $past(state_wr))
      else $error("enable rose without interrupt return");
   chk_stop_cause: assert property ($rose(osc_stop_out) |-> slp_p2)
      else $error("standby without sleep opcode");
   chk_stop_holds: assert property (osc_stop_out && !ctrl_wr |=> osc_stop_out)
      else $error("standby left without wake");
   chk_pc_step: assert property (nrst_in && !osc_stop_out && !rtn_p1 && !slp_p1 |=>
      pm_addr_out == $past(pm_addr_out) + 1'b1)
      else $error("program counter did not step");
endmodule

bind cie_core cie_core_assertions cie_core_assertions_inst (.*);

// file: cie_mem_model.sv
// Purpose: Program memory and file register beside the core
// Assumes: Reads are combinational, writes land on the clock edge
// Notes:   Contents are loaded by the bench through hierarchy
module cie_mem_model
   import cie_pkg::*;
(
   // Clock
   input  wire logic            clk_sys_in,
   // Program memory
   input  wire logic [PC_W-1:0] pm_addr_in,
   output logic      [OP_W-1:0] pm_data_out,
   // File register
   input  wire logic [FA_W-1:0] fr_addr_in,
   output logic      [DW-1:0]   fr_rdata_out,
   input  wire logic            fr_wr_in,
   input  wire logic [DW-1:0]   fr_wdata_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [OP_W-1:0] pm_mem [0:4095];
   logic [DW-1:0]   fr_mem [0:127]; // Whole 7-bit space
   logic [FA_W-1:0] wr_addr_q;

   // Combinational reads
   assign pm_data_out  = pm_mem[pm_addr_in];
   assign fr_rdata_out = fr_mem[fr_addr_in];

   // Write pulse trails execute, so keep the operand seen then
   always @(posedge clk_sys_in) begin
      if (fr_wr_in) begin
         fr_mem[wr_addr_q] <= fr_wdata_in;
      end
      wr_addr_q <= fr_addr_in;
   end
endmodule

// file: cie_core_tb.sv
// Purpose: Runs a short program through the core and checks results
// Assumes: Core fetches from address 0 right after reset
// Notes:   Return addresses are seeded over APB while no-ops run
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module cie_core_tb
   import cie_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic            clk_sys_in = 1'b0, nrst_in = 1'b0;
   logic            psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0]     paddr_in = '0;
   logic [31:0]     pwdata_in = '0, prdata_out;
   logic            pready_out, pslverr_out, fr_wr_out, ien_out, osc_stop_out;
   logic [PC_W-1:0] pm_addr_out;
   logic [OP_W-1:0] pm_data_in;
   logic [FA_W-1:0] fr_addr_out;
   logic [DW-1:0]   fr_rdata_in, fr_wdata_out;
   int              bad_count = 0, cmp_count = 0, cyc = 0;
   // Program from 20h, operands, preload and expected file contents
   localparam logic [OP_W-1:0] PROG [24] = '{14'h1902, 14'h0221, 14'h00B0, 14'h1902,
      14'h02A2, 14'h02A3, 14'h0D20, 14'h00B1, 14'h0CA0, 14'h0E24, 14'h00B2, 14'h08A5,
      14'h1FAF, 14'h0624, 14'h00B3, 14'h19B5, 14'h06A6, 14'h00A7, 14'h08A1, 14'h0EA8,
      14'h0DA8, 14'h0003, 14'h0040, 14'h19EE};
   // 28h: swap then rotate back to back reads the value just written; 0Ah stays clear
   localparam logic [FA_W-1:0] FA [14] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
      7'h26, 7'h27, 7'h28, 7'h30, 7'h31, 7'h32, 7'h33, 7'h0A};
   localparam logic [DW-1:0] FI [14] = '{8'hE6, 8'h03, 8'h02, 8'h01, 8'hA5, 8'h00,
      8'hB5, 8'h00, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [DW-1:0] FV [14] = '{8'hF3, 8'h03, 8'h00, 8'hFF, 8'hA5, 8'h00,
      8'h00, 8'hB5, 8'h42, 8'h01, 8'hCC, 8'h5A, 8'h50, 8'h00};

   cie_core cie_core_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .pm_addr_out(pm_addr_out), .pm_data_in(pm_data_in),
      .fr_addr_out(fr_addr_out), .fr_rdata_in(fr_rdata_in), .fr_wr_out(fr_wr_out),
      .fr_wdata_out(fr_wdata_out), .ien_out(ien_out), .osc_stop_out(osc_stop_out));
   cie_mem_model cie_mem_model_inst (.clk_sys_in(clk_sys_in), .pm_addr_in(pm_addr_out),
      .pm_data_out(pm_data_in), .fr_addr_in(fr_addr_out), .fr_rdata_out(fr_rdata_in),
      .fr_wr_in(fr_wr_out), .fr_wdata_in(fr_wdata_out));

   // Clock and hang guard
   always #50 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [31:0] exp_rd, input logic exp_err);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_sys_in);
      end while (pready_out !== 1'b1);
      `CHK(pready_out, 1'b1)
      `CHK(pslverr_out, exp_err)
      if (!wr && !exp_err) `CHK(prdata_out, exp_rd)
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask

   initial begin
      for (int i = 0; i < 4096; i++) cie_mem_model_inst.pm_mem[i] = 14'h0000;
      for (int i = 0; i < 128; i++) cie_mem_model_inst.fr_mem[i] = 8'h00;
      for (int i = 0; i < 24; i++) cie_mem_model_inst.pm_mem[32 + i] = PROG[i];
      for (int i = 0; i < 14; i++) cie_mem_model_inst.fr_mem[FA[i]] = FI[i];
      cie_mem_model_inst.pm_mem[12'h040] = 14'h183C;
      cie_mem_model_inst.pm_mem[12'h041] = 14'h19EE; // Flushed
      cie_mem_model_inst.pm_mem[12'h048] = 14'h0060;
      cie_mem_model_inst.pm_mem[12'h049] = 14'h00A8; // Flushed
      cie_mem_model_inst.pm_mem[12'h050] = OPC_SLEEP;
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      `CHK(ien_out, 1'b0)
      // Seed returns while the leading no-ops run
      apb(1'b1, REG_STKPUSH, 32'h050, '0, 1'b0);
      apb(1'b1, REG_STKPUSH, 32'h048, '0, 1'b0);
      apb(1'b1, REG_STKPUSH, 32'h040, '0, 1'b0);
      apb(1'b1, REG_PC, 32'h0, '0, 1'b1);
      apb(1'b0, 12'h100, '0, '0, 1'b1);
      apb(1'b0, REG_CTRL, '0, 32'h0, 1'b0);
      for (int n = 0; n < 200 && osc_stop_out !== 1'b1; n++) @(posedge clk_sys_in);
      `CHK(osc_stop_out, 1'b1)
      `CHK(ien_out, 1'b1)
      // Accumulator 3Ch from literal return, flags all clear
      apb(1'b0, REG_STATE, '0, 32'h3C | 32'h1 << ST_IEN | 32'h1 << ST_SLEEP, 1'b0);
      // Software wake leaves standby
      apb(1'b1, REG_CTRL, 32'h1, '0, 1'b0);
      `CHK(osc_stop_out, 1'b0)
      for (int i = 0; i < 14; i++) begin
         `CHK(cie_mem_model_inst.fr_mem[FA[i]], FV[i])
      end
      tally_and_finish();
   end
endmodule
